/* hw/pmt_top.sv */
// Purpose: 8-bit period timer with prescaler, postscaler and APB registers
// Assumes: CLK_IN is the oscillator clock; APB inputs synchronous to it
// Notes: zero wait state slave; postscaled match event raises a level interrupt
//
// Design decision made here: the APB slave port.
`include "pmt_defines.svh"

module pmt_top
  import pmt_pkg::*;
#(
  parameter int AW = 12
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,

  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [AW-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,

  // interrupt
  output logic IRQ_OUT,

  // time base for waveform unit
  output pmt_timebase_s TIMEBASE_OUT,

  // match pulse for sync serial unit
  output logic SHIFT_MATCH_OUT
);

  // register state
  logic [7:0] period_counter_reg;
  logic [7:0] period_limit_reg;
  pmt_ctrl_s timer_control_reg;
  logic match_event_flag_reg;
  logic match_irq_en_reg;

  // read path and outputs
  logic [31:0] rdata_reg;
  logic rd_err_reg;
  logic period_pulse_reg;

  // timing chain
  logic [1:0] qdiv_reg;
  logic instr_tick;
  logic pre_tick;
  logic count_tick;
  logic match_now;
  logic post_done;
  logic scaler_clr;
  logic [3:0] pre_ratio_m1;

  // bus decode
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic wr_lane0;
  logic [AW-1:0] addr;
  logic wr_count;
  logic wr_ctrl;
  logic wr_limit;
  logic wr_flag_clr;
  logic wr_flag_en;
  logic clr_match;

  // address decoding, used by read and write paths
  function automatic logic addr_hit(
    input logic [AW-1:0] a,
    input logic [AW-1:0] target
  );
    addr_hit = (a == target);
  endfunction

  function automatic logic addr_mapped(input logic [AW-1:0] a);
    addr_mapped = addr_hit(a, AW'(`PMT_ADDR_COUNT)) ||
                  addr_hit(a, AW'(`PMT_ADDR_CTRL)) ||
                  addr_hit(a, AW'(`PMT_ADDR_LIMIT)) ||
                  addr_hit(a, AW'(`PMT_ADDR_FLAG)) ||
                  addr_hit(a, AW'(`PMT_ADDR_FLAG_CLR)) ||
                  addr_hit(a, AW'(`PMT_ADDR_FLAG_EN));
  endfunction

  // prescale select to ratio minus one
  function automatic logic [3:0] pre_decode(input logic [1:0] sel);
    if (sel == `PMT_PRE_SEL_RATIO1) begin
      pre_decode = `PMT_PRE_RATIO1_M1;
    end else if (sel == `PMT_PRE_SEL_RATIO4) begin
      pre_decode = `PMT_PRE_RATIO4_M1;
    end else begin
      pre_decode = `PMT_PRE_RATIO16_M1;
    end
  endfunction

  // register read value
  function automatic logic [31:0] read_word(
    input logic [AW-1:0] a,
    input logic [7:0] cnt,
    input logic [7:0] lim,
    input pmt_ctrl_s ctl,
    input logic flg,
    input logic en
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    if (addr_hit(a, AW'(`PMT_ADDR_COUNT))) begin
      w[7:0] = cnt;
    end else if (addr_hit(a, AW'(`PMT_ADDR_LIMIT))) begin
      w[7:0] = lim;
    end else if (addr_hit(a, AW'(`PMT_ADDR_CTRL))) begin
      // bit 7 stays zero
      w[`PMT_CTRL_MATCH_DIV_MSB:`PMT_CTRL_IN_DIV_LSB] = ctl;
    end else if (addr_hit(a, AW'(`PMT_ADDR_FLAG))) begin
      w[`PMT_FLAG_MATCH_BIT] = flg;
    end else if (addr_hit(a, AW'(`PMT_ADDR_FLAG_EN))) begin
      w[`PMT_FLAG_MATCH_BIT] = en;
    end
    read_word = w;
  endfunction

  // apb phases
  assign addr = PADDR_IN;
  assign setup_phase = PSEL_IN && !PENABLE_IN;
  assign access_phase = PSEL_IN && PENABLE_IN;
  assign wr_access = access_phase && PWRITE_IN && PREADY_OUT;
  assign wr_lane0 = wr_access && PSTRB_IN[0];

  assign wr_count = wr_lane0 && addr_hit(addr, AW'(`PMT_ADDR_COUNT));
  assign wr_ctrl = wr_lane0 && addr_hit(addr, AW'(`PMT_ADDR_CTRL));
  assign wr_limit = wr_lane0 && addr_hit(addr, AW'(`PMT_ADDR_LIMIT));
  assign wr_flag_clr = wr_lane0 && addr_hit(addr, AW'(`PMT_ADDR_FLAG_CLR));
  assign wr_flag_en = wr_lane0 && addr_hit(addr, AW'(`PMT_ADDR_FLAG_EN));
  assign clr_match = wr_flag_clr && PWDATA_IN[`PMT_FLAG_MATCH_BIT];

  // zero wait states
  assign PREADY_OUT = 1'b1;
  assign PRDATA_OUT = rdata_reg;
  assign PSLVERR_OUT = access_phase && rd_err_reg;

  // read data and error captured in the setup cycle
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rdata_reg <= 32'h0000_0000;
      rd_err_reg <= 1'b0;
    end else if (setup_phase) begin
      rd_err_reg <= !addr_mapped(addr);
      if (!PWRITE_IN) begin
        rdata_reg <= read_word(addr, period_counter_reg, period_limit_reg,
                               timer_control_reg, match_event_flag_reg,
                               match_irq_en_reg);
      end
    end
  end

  // instruction clock enable, oscillator / 4
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      qdiv_reg <= 2'h0;
    end else begin
      qdiv_reg <= qdiv_reg + 2'h1;
    end
  end

  assign instr_tick = (qdiv_reg == `PMT_QDIV_LAST);

  // stopped timer gates the prescaler input
  assign pre_tick = instr_tick && timer_control_reg.timer_run;
  assign pre_ratio_m1 = pre_decode(timer_control_reg.input_divider_select);

  // reset is handled inside the scalers by their own reset
  assign scaler_clr = wr_count || wr_ctrl;

  pmt_scaler #(
    .W(4)
  ) u_prescaler (
    .clk_in(CLK_IN),
    .rst_in(RESET_IN),
    .clr_in(scaler_clr),
    .tick_in(pre_tick),
    .ratio_m1_in(pre_ratio_m1),
    .done_out(count_tick)
  );

  assign match_now = count_tick && (period_counter_reg == period_limit_reg);

  pmt_scaler #(
    .W(4)
  ) u_postscaler (
    .clk_in(CLK_IN),
    .rst_in(RESET_IN),
    .clr_in(scaler_clr),
    .tick_in(match_now),
    .ratio_m1_in(timer_control_reg.match_divider_select),
    .done_out(post_done)
  );

  // counter: software write wins over counting
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      period_counter_reg <= `PMT_COUNT_RST;
    end else if (wr_count) begin
      period_counter_reg <= PWDATA_IN[7:0];
    end else if (match_now) begin
      period_counter_reg <= `PMT_COUNT_RST;
    end else if (count_tick) begin
      period_counter_reg <= period_counter_reg + 8'h01;
    end
  end

  // period limit
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      period_limit_reg <= `PMT_LIMIT_RST;
    end else if (wr_limit) begin
      period_limit_reg <= PWDATA_IN[7:0];
    end
  end

  // control; a write here never touches the counter
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      timer_control_reg <= `PMT_CTRL_RST;
    end else if (wr_ctrl) begin
      timer_control_reg <=
        PWDATA_IN[`PMT_CTRL_MATCH_DIV_MSB:`PMT_CTRL_IN_DIV_LSB];
    end
  end

  // sticky match flag, set beats clear
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      match_event_flag_reg <= `PMT_FLAG_RST;
    end else if (post_done) begin
      match_event_flag_reg <= 1'b1;
    end else if (clr_match) begin
      match_event_flag_reg <= 1'b0;
    end
  end

  // interrupt enable
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      match_irq_en_reg <= `PMT_EN_RST;
    end else if (wr_flag_en) begin
      match_irq_en_reg <= PWDATA_IN[`PMT_FLAG_MATCH_BIT];
    end
  end

  assign IRQ_OUT = match_event_flag_reg && match_irq_en_reg;

  // registered match pulse for the neighbour units
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      period_pulse_reg <= 1'b0;
    end else begin
      period_pulse_reg <= match_now;
    end
  end

  assign TIMEBASE_OUT.count = period_counter_reg;
  assign TIMEBASE_OUT.period_pulse = period_pulse_reg;
  assign SHIFT_MATCH_OUT = period_pulse_reg;

endmodule

/* hw/pmt_defines.svh */
// Purpose: register map, field positions, reset values and timing counts
// Assumes: 32-bit APB data, each register on one aligned word
// Notes: printed offsets are register indices, byte address is index * 4
`ifndef PMT_DEFINES_SVH
`define PMT_DEFINES_SVH

// register indices
`define PMT_IDX_COUNT 10'h011
`define PMT_IDX_CTRL 10'h012
`define PMT_IDX_LIMIT 10'h013
`define PMT_IDX_FLAG 10'h00C
`define PMT_IDX_FLAG_CLR 10'h020
`define PMT_IDX_FLAG_EN 10'h021

// byte addresses
`define PMT_ADDR_COUNT {`PMT_IDX_COUNT, 2'b00}
`define PMT_ADDR_CTRL {`PMT_IDX_CTRL, 2'b00}
`define PMT_ADDR_LIMIT {`PMT_IDX_LIMIT, 2'b00}
`define PMT_ADDR_FLAG {`PMT_IDX_FLAG, 2'b00}
`define PMT_ADDR_FLAG_CLR {`PMT_IDX_FLAG_CLR, 2'b00}
`define PMT_ADDR_FLAG_EN {`PMT_IDX_FLAG_EN, 2'b00}

// control field positions
`define PMT_CTRL_IN_DIV_LSB 0
`define PMT_CTRL_IN_DIV_MSB 1
`define PMT_CTRL_RUN_BIT 2
`define PMT_CTRL_MATCH_DIV_LSB 3
`define PMT_CTRL_MATCH_DIV_MSB 6

// flag position
`define PMT_FLAG_MATCH_BIT 1

// reset values
`define PMT_COUNT_RST 8'h00
`define PMT_LIMIT_RST 8'hFF
`define PMT_CTRL_RST 7'h00
`define PMT_FLAG_RST 1'b0
`define PMT_EN_RST 1'b0

// timing: instruction clock is oscillator / 4
`define PMT_QDIV_LAST 2'h3
`define PMT_PRE_RATIO1_M1 4'h0
`define PMT_PRE_RATIO4_M1 4'h3
`define PMT_PRE_RATIO16_M1 4'hF
`define PMT_PRE_SEL_RATIO1 2'b00
`define PMT_PRE_SEL_RATIO4 2'b01

`endif

/* hw/pmt_pkg.sv */
// Purpose: shared types of the period match timer
// Assumes: nothing beyond the defines header
// Notes: control fields travel as one packed struct
package pmt_pkg;

  typedef struct packed {
    logic [3:0] match_divider_select;
    logic timer_run;
    logic [1:0] input_divider_select;
  } pmt_ctrl_s;

  typedef struct packed {
    logic [7:0] count;
    logic period_pulse;
  } pmt_timebase_s;

endpackage

/* hw/pmt_scaler.sv */
// Purpose: divide a tick stream by a programmable ratio
// Assumes: ratio_m1_in is ratio minus one
// Notes: clear has priority over counting
module pmt_scaler #(
  parameter int W = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clr_in,
  input wire logic tick_in,
  input wire logic [W-1:0] ratio_m1_in,
  output logic done_out
);

  logic [W-1:0] cnt_reg;

  // >= keeps a shrunk ratio from wrapping the full range
  // a clearing write swallows the tick of its own cycle
  assign done_out = tick_in && !clr_in && (cnt_reg >= ratio_m1_in);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
    end else if (clr_in) begin
      cnt_reg <= '0;
    end else if (tick_in) begin
      if (done_out) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule

/* verif/pmt_monitor.sv */
// Purpose: port checker for the period match timer
// Assumes: bound to pmt_top, write takes effect at the access edge
// Notes: run bit tracked from control writes
`include "pmt_defines.svh"
module pmt_monitor
  import pmt_pkg::*;
#(
  parameter int AW = 12
) (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [AW-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  input wire logic PREADY_OUT,
  input wire logic IRQ_OUT,
  input wire pmt_timebase_s TIMEBASE_OUT,
  input wire logic SHIFT_MATCH_OUT
);
  logic wr_acc;
  logic wr_cnt;
  logic wr_ctl;
  logic wr_d;
  logic run_reg;
  logic [7:0] cnt;
  assign cnt = TIMEBASE_OUT.count;
  assign wr_acc = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PSTRB_IN[0];
  assign wr_cnt = wr_acc && (PADDR_IN == `PMT_ADDR_COUNT);
  assign wr_ctl = wr_acc && (PADDR_IN == `PMT_ADDR_CTRL);
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) wr_d <= 1'b0;
    else wr_d <= wr_cnt;
  end
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) run_reg <= 1'b0;
    else if (wr_ctl) run_reg <= PWDATA_IN[`PMT_CTRL_RUN_BIT];
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  pulse_same_a: assert property (SHIFT_MATCH_OUT == TIMEBASE_OUT.period_pulse)
    else $error("shift match differs from period pulse");
  pulse_single_a: assert property (TIMEBASE_OUT.period_pulse |=> !TIMEBASE_OUT.period_pulse)
    else $error("period pulse longer than one cycle");
  wrap_zero_a: assert property (TIMEBASE_OUT.period_pulse |-> cnt == 8'h00)
    else $error("count not zero after match");
  count_step_a: assert property ($changed(cnt) && !wr_d |->
    cnt == 8'($past(cnt) + 8'h01) || cnt == 8'h00) else $error("count jumped");
  tick_gap_a: assert property ($changed(cnt) && !wr_d |=>
    (!$changed(cnt) || wr_d)[*3]) else $error("count ticks too close");
  run_stop_a: assert property (!run_reg && !wr_cnt |=> $stable(cnt))
    else $error("count moved while stopped");
  ctrl_keep_a: assert property (wr_ctl |=> $stable(cnt))
    else $error("control write changed count");
  irq_sticky_a: assert property (IRQ_OUT && !wr_acc |=> IRQ_OUT)
    else $error("interrupt dropped without a write");
  cover property (TIMEBASE_OUT.period_pulse);
  cover property ($rose(IRQ_OUT));
  cover property (wr_ctl);
endmodule

bind pmt_top pmt_monitor #(.AW(AW)) pmt_monitor_i (
  .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN),
  .PREADY_OUT(PREADY_OUT), .IRQ_OUT(IRQ_OUT), .TIMEBASE_OUT(TIMEBASE_OUT),
  .SHIFT_MATCH_OUT(SHIFT_MATCH_OUT)
);

/* verif/period_match_timer_tb.sv */
// Purpose: register level bench for the period match timer
// Assumes: zero wait apb slave, 100 MHz clock
// Notes: period is checked with limit 2 for every prescale code
`include "pmt_defines.svh"
module period_match_timer_tb
  import pmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pslverr;
  logic pready;
  logic irq;
  logic shift;
  pmt_timebase_s tbase;
  int err_count = 0;
  int n_tests = 0;
  pmt_top pmt_top_i (
    .CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(4'hF), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .IRQ_OUT(irq), .TIMEBASE_OUT(tbase),
    .SHIFT_MATCH_OUT(shift)
  );
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 50) begin
      err_count++;
      test_done();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask
  task automatic wait_pulse(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (tbase.period_pulse !== 1'b1 && n < 1000);
    if (n >= 1000) begin
      err_count++;
      test_done();
    end
  endtask
  initial begin
    int n;
    int p;
    logic [31:0] r;
    logic e;
    int ratio [4];
    ratio = '{1, 4, 16, 16};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(`PMT_ADDR_COUNT, 32'h0);
    rd(`PMT_ADDR_CTRL, 32'h0);
    wr(`PMT_ADDR_COUNT, 32'h5A);
    rd(`PMT_ADDR_COUNT, 32'h5A);
    wr(`PMT_ADDR_LIMIT, 32'hA5);
    rd(`PMT_ADDR_LIMIT, 32'hA5);
    wr(`PMT_ADDR_CTRL, 32'hF8);
    rd(`PMT_ADDR_CTRL, 32'h78);
    repeat (40) @(posedge clk);
    rd(`PMT_ADDR_COUNT, 32'h5A);
    wr(`PMT_ADDR_CTRL, 32'h03);
    rd(`PMT_ADDR_COUNT, 32'h5A);
    apb(1'b0, 12'hFFC, 32'h0, r, e);
    chk({r[31:1], e}, 32'h1);
    wr(`PMT_ADDR_LIMIT, 32'h02);
    for (int s = 0; s < 4; s++) begin
      wr(`PMT_ADDR_COUNT, 32'h0);
      wr(`PMT_ADDR_CTRL, 32'h4 | 32'(s));
      wait_pulse(n);
      wait_pulse(n);
      chk(32'(n), 32'(12 * ratio[s]));
    end
    wr(`PMT_ADDR_CTRL, 32'h0);
    wr(`PMT_ADDR_COUNT, 32'h0);
    wr(`PMT_ADDR_FLAG_CLR, 32'h2);
    rd(`PMT_ADDR_FLAG, 32'h0);
    wr(`PMT_ADDR_FLAG_EN, 32'h2);
    wr(`PMT_ADDR_CTRL, 32'h14);
    p = 0;
    do begin
      wait_pulse(n);
      p++;
      @(posedge clk);
      #1;
    end while (irq !== 1'b1 && p < 20);
    chk(32'(p), 32'h3);
    wr(`PMT_ADDR_CTRL, 32'h0);
    rd(`PMT_ADDR_FLAG, 32'h2);
    wr(`PMT_ADDR_FLAG_EN, 32'h0);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(`PMT_ADDR_FLAG_EN, 32'h2);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(`PMT_ADDR_FLAG_CLR, 32'h2);
    rd(`PMT_ADDR_FLAG, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // second reset in mid-run must clear the counter again
    wr(`PMT_ADDR_COUNT, 32'h33);
    rd(`PMT_ADDR_COUNT, 32'h33);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`PMT_ADDR_COUNT, 32'h0);
    test_done();
  end
endmodule
